// *** verilog/rpm_pkg.sv ***
// package of constants and carrier types for the remappable pin multiplexer
package rpm_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int NUM_PINS = 26; // remappable pins
   localparam int NUM_IN_REGS = 13; // input select registers
   localparam int NUM_OUT_REGS = 8; // output select registers
   localparam int NUM_IN_FIELDS = 2 * NUM_IN_REGS; // peripheral input selects
   localparam int NUM_OUT_PINS = 2 * NUM_OUT_REGS; // pins with an output select
   localparam int SEL_W = 5; // width of every select field
   localparam int REG_W = 16; // width of every mapping register

   // ****************************************************************
   // field layout and reset values
   // ****************************************************************
   localparam int LO_LSB = 0; // low field position
   localparam int HI_LSB = 8; // high field position
   localparam int BYTE_W = 8; // one byte lane
   localparam logic [REG_W-1:0] IN0_MASK = 16'h1f00; // first input register
   localparam logic [REG_W-1:0] FIELD_MASK = 16'h1f1f; // two fields
   localparam logic [REG_W-1:0] IN0_RESET = 16'h1f00; // ground select
   localparam logic [REG_W-1:0] IN_RESET = 16'h1f1f; // ground select, both
   localparam logic [REG_W-1:0] OUT_RESET = 16'h0000; // null select

   // ****************************************************************
   // select codes
   // ****************************************************************
   localparam logic [SEL_W-1:0] SEL_GROUND = 5'h1f; // input tied low
   localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19; // highest pin index
   localparam logic [SEL_W-1:0] OUT_NULL = 5'h00; // port logic owns pin
   localparam logic [SEL_W-1:0] OUT_TX = 5'h03;
   localparam logic [SEL_W-1:0] OUT_RTS = 5'h04;
   localparam logic [SEL_W-1:0] OUT_SDO = 5'h07;
   localparam logic [SEL_W-1:0] OUT_SCK = 5'h08;
   localparam logic [SEL_W-1:0] OUT_SS = 5'h09;
   localparam logic [SEL_W-1:0] OUT_OC1 = 5'h12;
   localparam logic [SEL_W-1:0] OUT_OC2 = 5'h13;
   localparam logic [SEL_W-1:0] OUT_ENCODER_DIRECTION_STATUS = 5'h1a;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] IN_BASE = 8'h00; // input selects, 13 words
   localparam logic [ADDR_W-1:0] OUT_BASE = 8'h40; // output selects, 8 words
   localparam logic [ADDR_W-1:0] OSC_ADDR = 8'h60; // oscillator control
   localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h64; // block status
   localparam int LOCK_BIT = 6; // write lock in oscillator control
   localparam logic [BYTE_W-1:0] KEY1 = 8'h46; // first unlock key
   localparam logic [BYTE_W-1:0] KEY2 = 8'h57; // second unlock key
   localparam int STAT_MISMATCH_BIT = 0; // sticky shadow mismatch
   localparam int STAT_ONEWAY_BIT = 1; // single session option seen

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_TWO} rpm_key_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } rpm_avm_req_t;

   typedef struct packed {
      logic tx;
      logic rts;
      logic sdo;
      logic sck;
      logic ss;
      logic oc1;
      logic oc2;
      logic encoder_direction_status;
   } rpm_periph_out_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] pin_meta;
      logic [NUM_PINS-1:0] pin_sync;
      logic opt_meta;
      logic opt_sync;
      logic waitreq;
      logic [31:0] rdata;
      rpm_key_t key;
      logic lock;
      logic [NUM_IN_REGS-1:0][REG_W-1:0] in_sel;
      logic [NUM_IN_REGS-1:0][REG_W-1:0] in_shadow;
      logic [NUM_OUT_REGS-1:0][REG_W-1:0] out_sel;
      logic [NUM_OUT_REGS-1:0][REG_W-1:0] out_shadow;
      logic mismatch;
      logic mismatch_seen;
      logic [NUM_IN_FIELDS-1:0] periph_in;
      logic [NUM_PINS-1:0] pin_out;
      logic [NUM_PINS-1:0] pin_oe;
   } rpm_state_t;

endpackage

// *** verilog/rpm_top.sv ***
// remappable peripheral pin multiplexer with locked mapping registers
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each peripheral input except input 0 owns a 5-bit pin select
// - only supported pin values accepted on write
// - all ones select ties the input low
// - codes zero to 25 pick that pin
// - first input register: field bits 12-8 only
// - pin input passes only when direction is input
// - pins 0 to 15 each own a 5-bit output select
// - null code hands pin to port logic
// - codes 3,4 drive serial transmit, request-to-send
// - codes 7,8,9 drive spi data, clock, select
// - codes 18,19 drive compare channels 1,2
// - code 26 drives encoder direction status
// - input and output mapping fully independent
// - locked map writes complete but change nothing
// - lock is oscillator control bit 6
// - keys 0x46, 0x57 then one lock write
// - lock holds value until software changes it
// - shadow compare raises mismatch reset on difference
// - single session option keeps lock set once set
// - single session and locked ignores key sequence
// - option high means one session, low unlimited
// - thirteen input and eight output select registers
module rpm_top (
   input wire logic sys_clk, // system clock
   input wire logic resetn, // synchronous reset, low
   input wire rpm_pkg::rpm_avm_req_t avs_req, // avalon request group
   output logic avs_waitrequest, // avalon wait
   output logic [31:0] avs_readdata, // avalon read data
   input wire logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_in, // pin levels
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_direction_reg, // 1 = input
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_out, // port logic data
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_oe, // port logic enable
   input wire rpm_pkg::rpm_periph_out_t periph_out, // peripheral outputs
   input wire logic single_session_lock_option, // config word bit
   output logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_out, // pin data
   output logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_oe, // pin enable
   output logic [rpm_pkg::NUM_IN_FIELDS-1:0] periph_in, // peripheral inputs
   output logic map_write_lock, // current lock
   output logic config_mismatch_reset // shadow mismatch reset request
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   // pick a pin level for a peripheral input select
   function automatic logic pick_in(input logic [rpm_pkg::SEL_W-1:0] sel,
                                    input logic [rpm_pkg::NUM_PINS-1:0] pins,
                                    input logic [rpm_pkg::NUM_PINS-1:0] dir);
      logic v;
      v = 1'b0;
      if (sel <= rpm_pkg::SEL_MAX_PIN) begin
         v = pins[sel] & dir[sel];
      end
      return v; // ground code and gaps read low
   endfunction

   // pick a peripheral output for a pin; msb says a known code
   function automatic logic [1:0] pick_out(input logic [rpm_pkg::SEL_W-1:0] code,
                                           input rpm_pkg::rpm_periph_out_t po);
      logic [1:0] r;
      r = 2'h0;
      unique case (code)
         rpm_pkg::OUT_TX: r = {1'b1, po.tx};
         rpm_pkg::OUT_RTS: r = {1'b1, po.rts};
         rpm_pkg::OUT_SDO: r = {1'b1, po.sdo};
         rpm_pkg::OUT_SCK: r = {1'b1, po.sck};
         rpm_pkg::OUT_SS: r = {1'b1, po.ss};
         rpm_pkg::OUT_OC1: r = {1'b1, po.oc1};
         rpm_pkg::OUT_OC2: r = {1'b1, po.oc2};
         rpm_pkg::OUT_ENCODER_DIRECTION_STATUS: r = {1'b1, po.encoder_direction_status};
         default: r = 2'h0; // null and unused codes go to port
      endcase
      return r;
   endfunction

   // merge a write into a mapping register, byte lane by lane
   function automatic logic [rpm_pkg::REG_W-1:0] upd_reg(
         input logic [rpm_pkg::REG_W-1:0] old,
         input logic [rpm_pkg::REG_W-1:0] wd,
         input logic [1:0] be,
         input logic [rpm_pkg::REG_W-1:0] mask,
         input logic chk_range);
      logic [rpm_pkg::REG_W-1:0] r;
      logic [rpm_pkg::SEL_W-1:0] f;
      r = old;
      f = '0;
      for (int h = 0; h < 2; h++) begin
         f = wd[h*rpm_pkg::BYTE_W +: rpm_pkg::SEL_W];
         if (be[h] && mask[h*rpm_pkg::BYTE_W]) begin
            // unsupported pin values leave the field alone
            if (!chk_range || f <= rpm_pkg::SEL_MAX_PIN || f == rpm_pkg::SEL_GROUND) begin
               r[h*rpm_pkg::BYTE_W +: rpm_pkg::SEL_W] = f;
            end
         end
      end
      return r & mask; // unimplemented bits stay zero
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   rpm_pkg::rpm_state_t state_ff; // all registers of the block
   rpm_pkg::rpm_state_t nxt_state; // next value of all registers

   // ****************************************************************
   // next state
   // ****************************************************************

   // bus slave, lock sequence, mapping registers and muxes
   always_comb begin
      logic req;
      logic oneway_locked;
      logic [rpm_pkg::ADDR_W-1:0] a;
      logic [rpm_pkg::REG_W-1:0] wd16;
      logic [rpm_pkg::BYTE_W-1:0] wd8;
      logic [rpm_pkg::SEL_W-1:0] sel;
      logic [1:0] po;
      int idx;
      req = 1'b0;
      oneway_locked = 1'b0;
      a = '0;
      wd16 = '0;
      wd8 = '0;
      sel = '0;
      po = 2'h0;
      idx = 0;
      nxt_state = state_ff;

      // two-stage synchronisers for pins and the option strap
      nxt_state.pin_meta = remappable_pin_n_in;
      nxt_state.pin_sync = state_ff.pin_meta;
      nxt_state.opt_meta = single_session_lock_option;
      nxt_state.opt_sync = state_ff.opt_meta;

      req = avs_req.read | avs_req.write;
      a = avs_req.address;
      wd16 = avs_req.writedata[rpm_pkg::REG_W-1:0];
      wd8 = avs_req.writedata[rpm_pkg::BYTE_W-1:0];
      // option high is the unprogrammed one-session default
      oneway_locked = state_ff.opt_sync & state_ff.lock;

      // one wait cycle, then a one-cycle answer
      nxt_state.waitreq = !(req && state_ff.waitreq);

      // read data prepared during the wait cycle
      if (req && state_ff.waitreq) begin
         nxt_state.rdata = '0; // unmapped addresses read zero
         if (a[1:0] == 2'h0) begin
            if (a >= rpm_pkg::IN_BASE && a < rpm_pkg::OUT_BASE) begin
               idx = int'(a[7:2]) - int'(rpm_pkg::IN_BASE[7:2]);
               if (idx < rpm_pkg::NUM_IN_REGS) begin
                  nxt_state.rdata[rpm_pkg::REG_W-1:0] = state_ff.in_sel[idx];
               end
            end else if (a >= rpm_pkg::OUT_BASE && a < rpm_pkg::OSC_ADDR) begin
               idx = int'(a[7:2]) - int'(rpm_pkg::OUT_BASE[7:2]);
               if (idx < rpm_pkg::NUM_OUT_REGS) begin
                  nxt_state.rdata[rpm_pkg::REG_W-1:0] = state_ff.out_sel[idx];
               end
            end else if (a == rpm_pkg::OSC_ADDR) begin
               nxt_state.rdata[rpm_pkg::LOCK_BIT] = state_ff.lock;
            end else if (a == rpm_pkg::STAT_ADDR) begin
               nxt_state.rdata[rpm_pkg::STAT_MISMATCH_BIT] = state_ff.mismatch_seen;
               nxt_state.rdata[rpm_pkg::STAT_ONEWAY_BIT] = state_ff.opt_sync;
            end
         end
      end

      // write takes effect on the handshake edge only
      if (avs_req.write && !state_ff.waitreq) begin
         nxt_state.key = rpm_pkg::KEY_IDLE; // any other write breaks the keys
         if (a == rpm_pkg::OSC_ADDR && avs_req.byteenable[0]) begin
            unique case (state_ff.key)
               rpm_pkg::KEY_IDLE: begin
                  // sequence ignored while one-way locked
                  if (wd8 == rpm_pkg::KEY1 && !oneway_locked) begin
                     nxt_state.key = rpm_pkg::KEY_ONE;
                  end
               end
               rpm_pkg::KEY_ONE: begin
                  if (wd8 == rpm_pkg::KEY2) begin
                     nxt_state.key = rpm_pkg::KEY_TWO;
                  end else if (wd8 == rpm_pkg::KEY1) begin
                     nxt_state.key = rpm_pkg::KEY_ONE;
                  end
               end
               rpm_pkg::KEY_TWO: begin
                  if (!oneway_locked) begin
                     nxt_state.lock = wd8[rpm_pkg::LOCK_BIT];
                  end
               end
            endcase
         end
         // mapping writes dropped silently while locked
         if (!state_ff.lock && a[1:0] == 2'h0) begin
            if (a >= rpm_pkg::IN_BASE && a < rpm_pkg::OUT_BASE) begin
               idx = int'(a[7:2]) - int'(rpm_pkg::IN_BASE[7:2]);
               if (idx < rpm_pkg::NUM_IN_REGS) begin
                  nxt_state.in_sel[idx] = upd_reg(state_ff.in_sel[idx], wd16,
                     avs_req.byteenable[1:0],
                     (idx == 0) ? rpm_pkg::IN0_MASK : rpm_pkg::FIELD_MASK, 1'b1);
                  nxt_state.in_shadow[idx] = nxt_state.in_sel[idx];
               end
            end else if (a >= rpm_pkg::OUT_BASE && a < rpm_pkg::OSC_ADDR) begin
               idx = int'(a[7:2]) - int'(rpm_pkg::OUT_BASE[7:2]);
               if (idx < rpm_pkg::NUM_OUT_REGS) begin
                  nxt_state.out_sel[idx] = upd_reg(state_ff.out_sel[idx], wd16,
                     avs_req.byteenable[1:0], rpm_pkg::FIELD_MASK, 1'b0);
                  nxt_state.out_shadow[idx] = nxt_state.out_sel[idx];
               end
            end
         end
      end

      // shadow compare; the sticky flag is only cleared by reset
      nxt_state.mismatch = (state_ff.in_sel != state_ff.in_shadow) ||
                           (state_ff.out_sel != state_ff.out_shadow);
      nxt_state.mismatch_seen = state_ff.mismatch_seen | nxt_state.mismatch;

      // peripheral input muxes, field 0 has no storage and stays grounded
      for (int i = 0; i < rpm_pkg::NUM_IN_FIELDS; i++) begin
         if (i == 0) begin
            sel = rpm_pkg::SEL_GROUND;
         end else if (i[0]) begin
            sel = state_ff.in_sel[i/2][rpm_pkg::HI_LSB +: rpm_pkg::SEL_W];
         end else begin
            sel = state_ff.in_sel[i/2][rpm_pkg::LO_LSB +: rpm_pkg::SEL_W];
         end
         nxt_state.periph_in[i] = pick_in(sel, state_ff.pin_sync,
                                          port_direction_reg);
      end

      // pin output muxes, pins past the selectable set stay with the port
      for (int p = 0; p < rpm_pkg::NUM_PINS; p++) begin
         nxt_state.pin_out[p] = port_out[p];
         nxt_state.pin_oe[p] = port_oe[p];
         if (p < rpm_pkg::NUM_OUT_PINS) begin
            if (p[0]) begin
               sel = state_ff.out_sel[p/2][rpm_pkg::HI_LSB +: rpm_pkg::SEL_W];
            end else begin
               sel = state_ff.out_sel[p/2][rpm_pkg::LO_LSB +: rpm_pkg::SEL_W];
            end
            po = pick_out(sel, periph_out);
            if (po[1]) begin
               nxt_state.pin_out[p] = po[0];
               nxt_state.pin_oe[p] = 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************

   // synchronous reset to defined values
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_ff <= '0;
         state_ff.waitreq <= 1'b1;
         state_ff.key <= rpm_pkg::KEY_IDLE;
         state_ff.lock <= 1'b0; // unlocked, held until written
         for (int r = 0; r < rpm_pkg::NUM_IN_REGS; r++) begin
            state_ff.in_sel[r] <= (r == 0) ? rpm_pkg::IN0_RESET : rpm_pkg::IN_RESET;
            state_ff.in_shadow[r] <= (r == 0) ? rpm_pkg::IN0_RESET : rpm_pkg::IN_RESET;
         end
         for (int r = 0; r < rpm_pkg::NUM_OUT_REGS; r++) begin
            state_ff.out_sel[r] <= rpm_pkg::OUT_RESET;
            state_ff.out_shadow[r] <= rpm_pkg::OUT_RESET;
         end
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign avs_waitrequest = state_ff.waitreq;
   assign avs_readdata = state_ff.rdata;
   assign remappable_pin_n_out = state_ff.pin_out;
   assign remappable_pin_n_oe = state_ff.pin_oe;
   assign periph_in = state_ff.periph_in;
   assign map_write_lock = state_ff.lock;
   assign config_mismatch_reset = state_ff.mismatch;

endmodule // rpm_top

`default_nettype wire

// *** verification/rpm_top_assertions.sv ***
// concurrent checks on the ports of the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module rpm_top_assertions (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire rpm_pkg::rpm_avm_req_t avs_req,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_in,
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_direction_reg,
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_out,
   input wire logic [rpm_pkg::NUM_PINS-1:0] port_oe,
   input wire logic single_session_lock_option,
   input wire logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_out,
   input wire logic [rpm_pkg::NUM_PINS-1:0] remappable_pin_n_oe,
   input wire logic [rpm_pkg::NUM_IN_FIELDS-1:0] periph_in,
   input wire logic map_write_lock,
   input wire logic config_mismatch_reset
);
   // ********************
   // helpers
   // ********************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic osc_done; // completed write to oscillator control
   logic [9:0] hi_out; // port data of pins without output select
   logic [9:0] hi_oe; // port enable of those pins
   assign osc_done = avs_req.write && !avs_waitrequest && avs_req.address == rpm_pkg::OSC_ADDR;
   assign hi_out = port_out[25:16];
   assign hi_oe = port_oe[25:16];
   // ********************
   // properties
   // ********************
   chk_wait_one: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_lock_cause: assert property ($changed(map_write_lock) |-> $past(osc_done))
      else $error("lock moved without a control write");
   chk_lock_oneway: assert property (single_session_lock_option && map_write_lock
      |=> map_write_lock) else $error("single session lock cleared");
   chk_pin_in: assert property (|periph_in |->
      |($past(remappable_pin_n_in, 3) & $past(port_direction_reg)))
      else $error("peripheral input high without an input pin");
   chk_port_pins: assert property ($past(resetn) |->
      remappable_pin_n_out[25:16] == $past(hi_out) && remappable_pin_n_oe[25:16] == $past(hi_oe))
      else $error("fixed pins left port logic");
   chk_no_mismatch: assert property (!config_mismatch_reset)
      else $error("mismatch reset on legal writes");
   chk_in0_ground: assert property (periph_in[0] == 1'b0)
      else $error("unimplemented input field active");
endmodule // rpm_top_assertions
`default_nettype wire

// *** verification/rpm_periph_model.sv ***
// on-chip peripheral outputs feeding the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module rpm_periph_model (
   input wire logic sys_clk,
   input wire logic resetn,
   output rpm_pkg::rpm_periph_out_t periph_out
);
   logic [7:0] lfsr_ff; // busy pattern, every output moves
   // ********************
   // pattern source
   // ********************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lfsr_ff <= 8'h5a;
      end else begin
         lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      end
   end
   assign periph_out = rpm_pkg::rpm_periph_out_t'(lfsr_ff);
endmodule // rpm_periph_model
`default_nettype wire

// *** verification/rpm_top_tb.sv ***
// self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module rpm_top_tb;
   typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} rpm_row_t;
   logic sys_clk, resetn, avs_waitrequest, single_session_lock_option;
   logic map_write_lock, config_mismatch_reset;
   rpm_pkg::rpm_avm_req_t avs_req; // bus request
   rpm_pkg::rpm_periph_out_t periph_out; // from model
   logic [31:0] avs_readdata, q;
   logic [25:0] remappable_pin_n_in, port_direction_reg, port_out, port_oe;
   logic [25:0] remappable_pin_n_out, remappable_pin_n_oe, periph_in;
   logic [7:0] pv; // peripheral outputs seen one edge early
   int n_fail, checked, k;
   logic [4:0] codes [8] = '{rpm_pkg::OUT_TX, rpm_pkg::OUT_RTS, rpm_pkg::OUT_SDO,
      rpm_pkg::OUT_SCK, rpm_pkg::OUT_SS, rpm_pkg::OUT_OC1, rpm_pkg::OUT_OC2, rpm_pkg::OUT_ENCODER_DIRECTION_STATUS};
   rpm_row_t rows [8] = '{ // write, then read back
      '{8'h00, 16'h0505, 16'h0500}, '{8'h04, 16'h1919, 16'h1919},
      '{8'h08, 16'h1a03, 16'h1f03}, '{8'h30, 16'he0ff, 16'h001f},
      '{8'h34, 16'h1234, 16'h0000}, '{8'h42, 16'h0303, 16'h0000},
      '{8'h5c, 16'h1a12, 16'h1a12}, '{8'h60, 16'h0000, 16'h0000}};
   rpm_top dut (.sys_clk, .resetn, .avs_req, .avs_waitrequest, .avs_readdata,
      .remappable_pin_n_in, .port_direction_reg, .port_out, .port_oe, .periph_out,
      .single_session_lock_option, .remappable_pin_n_out, .remappable_pin_n_oe,
      .periph_in, .map_write_lock, .config_mismatch_reset);
   rpm_periph_model u_model (.sys_clk, .resetn, .periph_out);
   // ********************
   // tasks
   // ********************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one bus cycle, held until waitrequest is seen low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      int i;
      @(posedge sys_clk);
      avs_req <= '{read: !w, write: w, address: a, byteenable: 4'h3, writedata: {16'h0000, d}};
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      if (i == 20) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      chk(q, {16'h0000, e});
   endtask
   // key pair then the lock value
   task automatic lock_seq(input logic [15:0] v);
      xfer(1'b1, 8'h60, 16'h0046);
      xfer(1'b1, 8'h60, 16'h0057);
      xfer(1'b1, 8'h60, v);
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
   endtask
   // ********************
   // clock and stimulus
   // ********************
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      {n_fail, checked} = '0;
      resetn = 1'b0;
      avs_req = '0;
      remappable_pin_n_in = 26'h0000000;
      port_direction_reg = '1;
      port_out = 26'h2aaaaaa;
      port_oe = 26'h1555555;
      single_session_lock_option = 1'b0;
      do_reset();
      for (k = 0; k < 8; k++) begin
         xfer(1'b1, rows[k].a, rows[k].d);
         rd(rows[k].a, rows[k].e);
      end
      // each output code on pin 0
      for (k = 0; k < 8; k++) begin
         xfer(1'b1, 8'h40, {11'h000, codes[k]});
         @(posedge sys_clk);
         #1 pv = periph_out;
         @(posedge sys_clk);
         #1 chk(remappable_pin_n_out[0], pv[7-k]);
         chk(remappable_pin_n_oe[0], 1'b1);
      end
      xfer(1'b1, 8'h40, 16'h0000);
      @(posedge sys_clk);
      #1 chk({remappable_pin_n_oe[1:0], remappable_pin_n_out[1:0]}, 4'h6);
      // pin 5 and pin 25 onto inputs 2 and 3, input 1 still on pin 5
      @(posedge sys_clk);
      remappable_pin_n_in <= 26'h2000020;
      xfer(1'b1, 8'h04, 16'h1905);
      repeat (4) @(posedge sys_clk);
      #1 chk(periph_in[3:0], 4'he);
      @(posedge sys_clk);
      port_direction_reg <= 26'h3ffffdf;
      repeat (2) @(posedge sys_clk);
      #1 chk(periph_in[3:2], 2'b10);
      xfer(1'b1, 8'h04, 16'h1f05);
      repeat (2) @(posedge sys_clk);
      #1 chk(periph_in[3:2], 2'b00);
      // lock, refused writes, unlock, multi write session
      lock_seq(16'h0040);
      #1 chk(map_write_lock, 1'b1);
      rd(8'h60, 16'h0040);
      xfer(1'b1, 8'h40, 16'h0303);
      xfer(1'b1, 8'h00, 16'h0000);
      rd(8'h40, 16'h0000);
      rd(8'h00, 16'h0500);
      lock_seq(16'h0000);
      rd(8'h60, 16'h0000);
      xfer(1'b1, 8'h40, 16'h0303);
      xfer(1'b1, 8'h44, 16'h0404);
      rd(8'h40, 16'h0303);
      rd(8'h44, 16'h0404);
      xfer(1'b1, 8'h60, 16'h0046);
      xfer(1'b1, 8'h40, 16'h0000);
      xfer(1'b1, 8'h60, 16'h0057);
      xfer(1'b1, 8'h60, 16'h0040);
      rd(8'h60, 16'h0000);
      // single session option, then reset values
      single_session_lock_option <= 1'b1;
      do_reset();
      lock_seq(16'h0040);
      lock_seq(16'h0000);
      rd(8'h60, 16'h0040);
      do_reset();
      rd(8'h60, 16'h0000);
      rd(8'h00, 16'h1f00);
      rd(8'h2c, 16'h1f1f);
      rd(8'h44, 16'h0000);
      rd(8'h64, 16'h0002);
      end_of_test();
   end
endmodule // rpm_top_tb
bind rpm_top rpm_top_assertions u_chk (.sys_clk, .resetn, .avs_req, .avs_waitrequest,
   .avs_readdata, .remappable_pin_n_in, .port_direction_reg, .port_out, .port_oe,
   .single_session_lock_option, .remappable_pin_n_out, .remappable_pin_n_oe,
   .periph_in, .map_write_lock, .config_mismatch_reset);
`default_nettype wire
